// ---- hw/ppmtw_pkg.sv ----
// Package for the port pin-match and timer-wait block.
// Assumes one core clock and an active-low asynchronous reset.
package ppmtw_pkg;

  localparam int unsigned PPMTW_PORT_WIDTH  = 8;
  localparam int unsigned PPMTW_VALUE_WIDTH = 32;
  localparam int unsigned PPMTW_COUNT_WIDTH = 16;
  localparam int unsigned PPMTW_TIMER_WIDTH = 32;

  localparam logic [PPMTW_PORT_WIDTH-1:0]  PPMTW_PINS_RESET  = 8'h00;
  localparam logic [PPMTW_COUNT_WIDTH-1:0] PPMTW_COUNT_RESET = 16'h0000;
  localparam logic [PPMTW_TIMER_WIDTH-1:0] PPMTW_TIMER_RESET = 32'h0000_0000;

  // Condition attached to a pending port input
  typedef enum logic [1:0] {
    PPMTW_COND_PINS_EQUAL,
    PPMTW_COND_PINS_DIFFER,
    PPMTW_COND_TIMED_PINS_EQUAL,
    PPMTW_COND_TIMED_PINS_DIFFER
  } ppmtw_cond_type;

  typedef struct packed {
    ppmtw_cond_type                  cond;
    logic [PPMTW_VALUE_WIDTH-1:0]    compare_value;
    logic [PPMTW_COUNT_WIDTH-1:0]    compare_time;
  } ppmtw_port_req_type;

  typedef struct packed {
    logic [PPMTW_PORT_WIDTH-1:0]     pins;
    logic [PPMTW_COUNT_WIDTH-1:0]    stamp;
  } ppmtw_port_data_type;

endpackage

// ---- hw/ppmtw_timer_wait.sv ----
// Free-running timer with one pending after-condition input.
// Assumes the arming pulse comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ppmtw_timer_wait
  import ppmtw_pkg::*;
(
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_arm,
  input  wire logic [PPMTW_TIMER_WIDTH-1:0]  i_after_time,
  output logic                               o_ready,
  output logic [PPMTW_TIMER_WIDTH-1:0]       o_time
);

  typedef enum logic [1:0] {
    PPMTW_TIMER_IDLE,
    PPMTW_TIMER_WAIT,
    PPMTW_TIMER_DONE
  } ppmtw_timer_state_type;

  ppmtw_timer_state_type          state_reg, state_next;
  logic [PPMTW_TIMER_WIDTH-1:0]   count_reg, count_next;
  logic [PPMTW_TIMER_WIDTH-1:0]   after_reg, after_next;
  logic [PPMTW_TIMER_WIDTH-1:0]   time_reg,  time_next;
  logic                           ready_reg, ready_next;
  logic [PPMTW_TIMER_WIDTH-1:0]   diff;
  logic                           is_after;

  always_comb begin
    count_next = count_reg + 32'h0000_0001;
    diff       = count_reg - after_reg;
    is_after   = !diff[PPMTW_TIMER_WIDTH-1] && (diff != PPMTW_TIMER_RESET);
    state_next = state_reg;
    after_next = after_reg;
    time_next  = time_reg;
    ready_next = 1'b0;
    case (state_reg)
      PPMTW_TIMER_IDLE: begin
        if (i_arm) begin
          after_next = i_after_time;
          state_next = PPMTW_TIMER_WAIT;
        end
      end
      PPMTW_TIMER_WAIT: begin
        if (is_after) begin
          ready_next = 1'b1;
          time_next  = count_reg;
          state_next = PPMTW_TIMER_DONE;
        end
      end
      default: begin
        state_next = PPMTW_TIMER_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PPMTW_TIMER_IDLE;
      count_reg <= PPMTW_TIMER_RESET;
      after_reg <= PPMTW_TIMER_RESET;
      time_reg  <= PPMTW_TIMER_RESET;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      after_reg <= after_next;
      time_reg  <= time_next;
      ready_reg <= ready_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_time  = time_reg;

endmodule
`default_nettype wire

// ---- hw/ppmtw_top.sv ----
// Port pin-match and timer-wait block: one conditional port input and one timer.
// Assumes pins are asynchronous to i_clock; requests come from same-clock logic.
// Timed conditions suit unbuffered ports only; the requester keeps to that.
//
// How it works
// - Equal condition: input ready once pins match low port-width bits of value.
// - Differ condition: input ready once pins differ from truncated value.
// - Timed equal: ready when pins match and port counter equals time.
// - Timed differ: ready when pins differ and port counter equals time.
// - Timer input ready once counter is later than the compare time.
`timescale 1ns/10ps
`default_nettype none
module ppmtw_top
  import ppmtw_pkg::*;
(
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  input  wire logic [PPMTW_PORT_WIDTH-1:0]   i_pins,
  input  wire logic                          i_port_arm,
  input  wire ppmtw_port_req_type            i_port_req,
  input  wire logic                          i_port_cancel,
  input  wire logic                          i_timer_arm,
  input  wire logic [PPMTW_TIMER_WIDTH-1:0]  i_timer_after,
  output ppmtw_port_data_type                o_port_data,
  output logic                               o_port_ready,
  output logic                               o_port_busy,
  output logic                               o_timer_ready,
  output logic [PPMTW_TIMER_WIDTH-1:0]       o_timer_time
);

  typedef enum logic [1:0] {
    PPMTW_PORT_IDLE,
    PPMTW_PORT_WAIT,
    PPMTW_PORT_DONE
  } ppmtw_port_state_type;

  // Synchroniser stages; only the second stage is read by logic
  logic [PPMTW_PORT_WIDTH-1:0]   pins_meta_reg;
  logic [PPMTW_PORT_WIDTH-1:0]   pins_meta_next;
  logic [PPMTW_PORT_WIDTH-1:0]   pins_sync_reg;
  logic [PPMTW_PORT_WIDTH-1:0]   pins_sync_next;

  // Port counter
  logic [PPMTW_COUNT_WIDTH-1:0]  count_reg;
  logic [PPMTW_COUNT_WIDTH-1:0]  count_next;

  // Pending input and its status flags
  ppmtw_port_state_type          state_reg;
  ppmtw_port_state_type          state_next;
  logic                          ready_reg;
  logic                          ready_next;
  logic                          busy_reg;
  logic                          busy_next;

  // Request held while the input is pending
  ppmtw_port_req_type            req_reg;
  ppmtw_port_req_type            req_next;

  // Data of the last completed input
  ppmtw_port_data_type           data_reg;
  ppmtw_port_data_type           data_next;

  // Condition terms
  logic [PPMTW_PORT_WIDTH-1:0]   compare_pins;
  logic [PPMTW_PORT_WIDTH-1:0]   bit_match;
  logic                          pins_equal;
  logic                          time_hit;
  logic                          cond_met;
  logic                          take_arm;
  logic                          complete;

  // Two-stage pin synchroniser
  always_comb begin
    pins_meta_next = i_pins;
    pins_sync_next = pins_meta_reg;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_meta_reg <= PPMTW_PINS_RESET;
      pins_sync_reg <= PPMTW_PINS_RESET;
    end else begin
      pins_meta_reg <= pins_meta_next;
      pins_sync_reg <= pins_sync_next;
    end
  end

  // Free-running port counter, wraps at its width
  always_comb begin
    count_next = count_reg + 16'h0001;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= PPMTW_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Low port-width bits of the compare value; upper bits are ignored
  assign compare_pins = req_reg.compare_value[PPMTW_PORT_WIDTH-1:0];

  // Per-bit match of the synchronised pins
  for (genvar b = 0; b < PPMTW_PORT_WIDTH; b++) begin : g_bit_match
    assign bit_match[b] = (pins_sync_reg[b] == compare_pins[b]);
  end

  // Pin and counter terms
  always_comb begin
    pins_equal = &bit_match;
    time_hit   = (count_reg == req_reg.compare_time);
  end

  // Condition select
  always_comb begin
    case (req_reg.cond)
      PPMTW_COND_PINS_EQUAL:        cond_met = pins_equal;
      PPMTW_COND_PINS_DIFFER:       cond_met = !pins_equal;
      PPMTW_COND_TIMED_PINS_EQUAL:  cond_met = pins_equal && time_hit;
      PPMTW_COND_TIMED_PINS_DIFFER: cond_met = !pins_equal && time_hit;
      default:                      cond_met = 1'b0;
    endcase
  end

  // Arm is taken only when idle; busy or done cycles ignore it
  assign take_arm = (state_reg == PPMTW_PORT_IDLE) && i_port_arm;

  // Cancel is checked first, so a cancelled input never completes
  assign complete = (state_reg == PPMTW_PORT_WAIT) && !i_port_cancel && cond_met;

  // Pending-input state and status flags
  always_comb begin
    state_next = state_reg;
    busy_next  = busy_reg;
    ready_next = 1'b0;
    case (state_reg)
      PPMTW_PORT_IDLE: begin
        if (take_arm) begin
          busy_next  = 1'b1;
          state_next = PPMTW_PORT_WAIT;
        end
      end
      PPMTW_PORT_WAIT: begin
        if (i_port_cancel) begin
          busy_next  = 1'b0;
          state_next = PPMTW_PORT_IDLE;
        end else if (complete) begin
          ready_next = 1'b1;
          busy_next  = 1'b0;
          state_next = PPMTW_PORT_DONE;
        end
      end
      default: begin
        state_next = PPMTW_PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PPMTW_PORT_IDLE;
      ready_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      busy_reg  <= busy_next;
    end
  end

  // Request latch
  always_comb begin
    req_next = req_reg;
    if (take_arm) begin
      req_next = i_port_req;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  // Completion data: pins and counter of the matching cycle, held until the next
  always_comb begin
    data_next = data_reg;
    if (complete) begin
      data_next.pins  = pins_sync_reg;
      data_next.stamp = count_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_reg <= '0;
    end else begin
      data_reg <= data_next;
    end
  end

  assign o_port_data  = data_reg;
  assign o_port_ready = ready_reg;
  assign o_port_busy  = busy_reg;

  // Timer with one pending after-condition input
  ppmtw_timer_wait u_timer (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_arm        (i_timer_arm),
    .i_after_time (i_timer_after),
    .o_ready      (o_timer_ready),
    .o_time       (o_timer_time)
  );

endmodule
`default_nettype wire

// ---- test/ppmtw_pin_src.sv ----
// Pin source: drives the port pins from a requested level.
// Assumes pins move out of phase with the core clock.
`timescale 1ns/10ps
`default_nettype none
module ppmtw_pin_src (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_level,
  output logic      [7:0] o_pins
);
  initial o_pins = 8'h00;
  always @(posedge i_clock) #3 o_pins = i_level;
endmodule
`default_nettype wire

// ---- test/ppmtw_props.sv ----
// Checker for the pin-match and timer-wait block.
// Assumes it is bound to ppmtw_top.
`timescale 1ns/10ps
`default_nettype none
module ppmtw_props
  import ppmtw_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  input  wire logic                i_port_arm,
  input  wire ppmtw_port_req_type  i_port_req,
  input  wire logic                i_port_cancel,
  input  wire logic                i_timer_arm,
  input  wire logic [31:0]         i_timer_after,
  input  wire ppmtw_port_data_type o_port_data,
  input  wire logic                o_port_ready,
  input  wire logic                o_port_busy,
  input  wire logic                o_timer_ready,
  input  wire logic [31:0]         o_timer_time
);
  ppmtw_port_req_type r;
  logic [31:0]        aft_reg;
  logic               tmr_busy_reg;
  // Timer arm is taken only when no timer input is pending or completing
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_busy_reg <= 1'b0;
    end else if (i_timer_arm && !tmr_busy_reg) begin
      tmr_busy_reg <= 1'b1;
    end else if (o_timer_ready) begin
      tmr_busy_reg <= 1'b0;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_port_arm && !o_port_busy && !o_port_ready) r <= i_port_req;
    if (i_timer_arm && !tmr_busy_reg) aft_reg <= i_timer_after;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_port_pulse: assert property (o_port_ready |=> !o_port_ready) else $error("port ready too long");
  a_ready_idle: assert property (o_port_ready |-> !o_port_busy) else $error("busy with ready");
  a_arm_busy: assert property (i_port_arm && !o_port_busy && !o_port_ready && !i_port_cancel
    |=> o_port_busy) else $error("arm not taken");
  a_eq_pins: assert property (o_port_ready && r.cond == PPMTW_COND_PINS_EQUAL |->
    o_port_data.pins == r.compare_value[7:0]) else $error("equal miss");
  a_ne_pins: assert property (o_port_ready && r.cond == PPMTW_COND_PINS_DIFFER |->
    o_port_data.pins != r.compare_value[7:0]) else $error("differ miss");
  a_teq_pins: assert property (o_port_ready && r.cond == PPMTW_COND_TIMED_PINS_EQUAL |->
    o_port_data.pins == r.compare_value[7:0] && o_port_data.stamp == r.compare_time)
    else $error("timed equal miss");
  a_tne_pins: assert property (o_port_ready && r.cond == PPMTW_COND_TIMED_PINS_DIFFER |->
    o_port_data.pins != r.compare_value[7:0] && o_port_data.stamp == r.compare_time)
    else $error("timed differ miss");
  a_timer_later: assert property (o_timer_ready |-> $signed(o_timer_time - aft_reg) > 0)
    else $error("timer early");
  a_timer_pulse: assert property (o_timer_ready |=> !o_timer_ready) else $error("timer ready too long");
  c_timed: cover property (o_port_ready && r.cond == PPMTW_COND_TIMED_PINS_DIFFER);
  c_cancel: cover property (o_port_busy && i_port_cancel);
  c_timer: cover property (o_timer_ready);
endmodule
bind ppmtw_top ppmtw_props u_ppmtw_props (.i_clock, .i_rst_n, .i_port_arm, .i_port_req, .i_port_cancel,
  .i_timer_arm, .i_timer_after, .o_port_data, .o_port_ready, .o_port_busy, .o_timer_ready, .o_timer_time);
`default_nettype wire

// ---- test/ppmtw_top_tb.sv ----
// Testbench for the pin-match and timer-wait block.
// Assumes the pin source model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module ppmtw_top_tb
  import ppmtw_pkg::*;
;
  logic                i_clock = 0, i_rst_n = 0, arm = 0, cancel = 0, tarm = 0, rdy, busy, trdy;
  logic [7:0]          lvl = 8'h00, pins;
  logic [31:0]         after = 0, cyc = 0, ttime;
  ppmtw_port_req_type  req = '0;
  ppmtw_port_data_type data;
  int                  n_mismatch = 0, tests_run = 0;
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) cyc <= cyc + 1;
  ppmtw_pin_src u_ppmtw_pin_src (.i_clock, .i_level(lvl), .o_pins(pins));
  ppmtw_top u_ppmtw_top (.i_clock, .i_rst_n, .i_pins(pins), .i_port_arm(arm), .i_port_req(req),
    .i_port_cancel(cancel), .i_timer_arm(tarm), .i_timer_after(after), .o_port_data(data),
    .o_port_ready(rdy), .o_port_busy(busy), .o_timer_ready(trdy), .o_timer_time(ttime));
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic arm_port(input ppmtw_cond_type c, input logic [31:0] v, input logic [15:0] t);
    @(posedge i_clock);
    arm <= 1;
    req <= '{c, v, t};
    @(posedge i_clock);
    arm <= 0;
  endtask
  task automatic wait_rdy(input int n, input logic exp);
    #1 repeat (n) if (rdy !== 1'b1) @(posedge i_clock) #1;
    `CHK("port ready", exp, rdy)
    if (exp && rdy !== 1'b1) summarize();
  endtask
  task automatic set_pins(input logic [7:0] v);
    @(posedge i_clock) lvl <= v;
    repeat (4) @(posedge i_clock);
  endtask
  task automatic s_equal();
    set_pins(8'h35);
    arm_port(PPMTW_COND_PINS_EQUAL, 32'hABCD_1234, 16'h0000);
    wait_rdy(8, 1'b0);
    @(posedge i_clock) lvl <= 8'h34;
    wait_rdy(8, 1'b1);
    `CHK("pins", 8'h34, data.pins)
  endtask
  task automatic s_differ();
    set_pins(8'h5A);
    arm_port(PPMTW_COND_PINS_DIFFER, 32'h0000_FF5A, 16'h0000);
    wait_rdy(8, 1'b0);
    @(posedge i_clock) lvl <= 8'h5B;
    wait_rdy(8, 1'b1);
    `CHK("pins", 8'h5B, data.pins)
  endtask
  task automatic s_timed(input ppmtw_cond_type c, input logic [7:0] p, input logic exp);
    logic [15:0] t;
    set_pins(p);
    t = cyc[15:0] + 16'h0028;
    arm_port(c, 32'h1234_0077, t);
    wait_rdy(30, 1'b0);
    wait_rdy(40, exp);
    if (exp) `CHK("stamp", t, data.stamp)
    if (exp) `CHK("pins", p, data.pins)
  endtask
  task automatic s_cancel();
    `CHK("busy", 1'b1, busy)
    @(posedge i_clock) cancel <= 1;
    @(posedge i_clock) cancel <= 0;
    #1 `CHK("busy", 1'b0, busy)
  endtask
  task automatic s_timer(input logic [31:0] t, input int n);
    @(posedge i_clock);
    tarm <= 1;
    after <= t;
    @(posedge i_clock);
    tarm <= 0;
    #1 repeat (n) if (trdy !== 1'b1) @(posedge i_clock) #1;
    `CHK("timer ready", 1'b1, trdy)
    if (trdy !== 1'b1) summarize();
    else `CHK("timer later", 1'b1, $signed(ttime - t) > 0)
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1;
    s_equal();
    s_differ();
    s_timed(PPMTW_COND_TIMED_PINS_EQUAL, 8'h77, 1'b1);
    s_timed(PPMTW_COND_TIMED_PINS_EQUAL, 8'h76, 1'b0);
    s_cancel();
    s_timed(PPMTW_COND_TIMED_PINS_DIFFER, 8'h77, 1'b0);
    s_cancel();
    s_timed(PPMTW_COND_TIMED_PINS_DIFFER, 8'h78, 1'b1);
    s_timer(cyc + 32'h0000_0014, 40);
    `CHK("timer time", after + 32'h0000_0001, ttime)
    s_timer(32'hFFFF_FFF0, 6);
    summarize();
  end
endmodule
`default_nettype wire
